/* design/cdc_pkg.sv */
// Function
// - Control bit 13 launches length and analysis test
// - Control bit 12 launches reflectometry test
// - Select field 10:8 routes results register
// - Control bit 0 picks transmit or receive pair
// - Status bit 15 shows analysis test done
// - Status 14 fail resets one, 13 done
// - Analysis input field 9:6 resets to seven
// - Status bit 5 enables signal analysis engine
// - Bit 4 picks raw or adaptive analysis
// - Results register returns selected diagnostic result
// - Enable bit 15 clears on reflectometry completion
// - Enable bit 14 clears on completion too
// - Pattern register works only with both enables
// - Amplitude codes 8 to 15 saturate full
// - Sixteen writes fill pattern in sequence
// - Each symbol driven for one clock of ten nanoseconds
package cdc_pkg;
    localparam logic [11:0] ADDR_CONTROL = 12'h01a;
    localparam logic [11:0] ADDR_STATUS  = 12'h01b;
    localparam logic [11:0] ADDR_RESULT  = 12'h01c;
    localparam logic [11:0] ADDR_SM_EN   = 12'h080;
    localparam logic [11:0] ADDR_PATTERN = 12'h090;

    localparam int CTL_LEN_START = 13;
    localparam int CTL_REF_START = 12;
    localparam int CTL_SEL_LO    = 8;
    localparam int CTL_PAIR      = 0;
    localparam int STS_LEN_DONE  = 15;
    localparam int STS_REF_FAIL  = 14;
    localparam int STS_REF_DONE  = 13;
    localparam int STS_RSVD_LO   = 10;
    localparam int STS_INPUT_LO  = 6;
    localparam int STS_ENG_EN    = 5;
    localparam int STS_RAW_MODE  = 4;
    localparam int SM_CONFIG     = 15;
    localparam int SM_TX_CONFIG  = 14;

    localparam logic [2:0]  STS_RSVD_RESET  = 3'h4;
    localparam logic [3:0]  INPUT_RESET     = 4'h7;
    localparam logic        RAW_MODE_RESET  = 1'b1;
    localparam logic        REF_FAIL_RESET  = 1'b1;
    localparam logic [2:0]  SEL_LENGTH      = 3'h6;
    localparam logic [2:0]  SEL_LAST_PEAK   = 3'h4;
    localparam logic [4:0]  AMP_FULL        = 5'h08;
    localparam int          PATTERN_LEN     = 16;
    localparam int          SYMBOL_NS       = 8;
    localparam int          CLK_PERIOD_NS   = 10;
    // Symbol is shorter than a clock period; one clock is the floor
    localparam int          SYMBOL_CYCLES_RAW = SYMBOL_NS / CLK_PERIOD_NS;
    localparam int          SYMBOL_CYCLES   = (SYMBOL_CYCLES_RAW < 1) ? 1 : SYMBOL_CYCLES_RAW;

    typedef enum logic [1:0] {
        CDC_TX_IDLE = 2'b00,
        CDC_TX_RUN  = 2'b01
    } cdc_tx_state_t;
endpackage : cdc_pkg

/* design/cdc_pattern_store.sv */
`timescale 1ns/1ns
module cdc_pattern_store (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    // Load side
    input  wire logic       armed,
    input  wire logic       load_we,
    input  wire logic [4:0] load_amp,
    // Playback side and load pointer
    input  wire logic       play_start,
    output logic      [4:0] play_level,
    output logic            play_active,
    output logic      [3:0] load_ptr
);
    localparam int PATTERN_LEN_L = cdc_pkg::PATTERN_LEN;
    logic [4:0] mem_q [PATTERN_LEN_L];
    logic [4:0] mem_d [PATTERN_LEN_L];
    logic [3:0] wptr_q, wptr_d, rptr_q, rptr_d;
    logic [7:0] hold_q, hold_d;
    logic [4:0] lvl_q, lvl_d;
    cdc_pkg::cdc_tx_state_t st_q, st_d;

    function automatic logic [4:0] sat_amp(input logic [4:0] a);
        sat_amp = (a >= cdc_pkg::AMP_FULL && a <= 5'h0f) ? cdc_pkg::AMP_FULL : a;
    endfunction : sat_amp

    always_comb begin
        mem_d  = mem_q;
        wptr_d = wptr_q;
        rptr_d = rptr_q;
        hold_d = hold_q;
        lvl_d  = lvl_q;
        st_d   = st_q;
        if (!armed) begin
            wptr_d = 4'h0;
        end else if (load_we) begin
            mem_d[wptr_q] = load_amp;
            wptr_d = wptr_q + 4'h1; // Wraps to zero after sixteenth
        end
        unique case (st_q)
            cdc_pkg::CDC_TX_IDLE: begin
                lvl_d = 5'h00;
                if (play_start && armed) begin
                    st_d   = cdc_pkg::CDC_TX_RUN;
                    rptr_d = 4'h0;
                    hold_d = 8'h00;
                    lvl_d  = sat_amp(mem_q[0]);
                end
            end
            cdc_pkg::CDC_TX_RUN: begin
                if (hold_q == 8'(cdc_pkg::SYMBOL_CYCLES - 1)) begin
                    hold_d = 8'h00;
                    if (rptr_q == 4'hf) begin
                        st_d  = cdc_pkg::CDC_TX_IDLE;
                        lvl_d = 5'h00;
                    end else begin
                        rptr_d = rptr_q + 4'h1;
                        lvl_d  = sat_amp(mem_q[rptr_q + 4'h1]);
                    end
                end else begin
                    hold_d = hold_q + 8'h01;
                end
            end
            default: st_d = cdc_pkg::CDC_TX_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            for (int i = 0; i < PATTERN_LEN_L; i++) mem_q[i] <= 5'h00;
            wptr_q <= 4'h0;
            rptr_q <= 4'h0;
            hold_q <= 8'h00;
            lvl_q  <= 5'h00;
            st_q   <= cdc_pkg::CDC_TX_IDLE;
        end else begin
            mem_q  <= mem_d;
            wptr_q <= wptr_d;
            rptr_q <= rptr_d;
            hold_q <= hold_d;
            lvl_q  <= lvl_d;
            st_q   <= st_d;
        end
    end

    assign play_level  = lvl_q;
    assign play_active = (st_q == cdc_pkg::CDC_TX_RUN);
    assign load_ptr    = wptr_q;

    chk_ptr_wrap: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (armed && load_we && wptr_q == 4'hf) |=> wptr_q == 4'h0)
        else $error("pointer did not wrap");
    chk_ptr_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !armed |=> wptr_q == 4'h0)
        else $error("pointer not cleared on disable");
    chk_level_sat: assert property (@(posedge sys_clk) disable iff (!rst_n)
        play_active |-> play_level <= cdc_pkg::AMP_FULL || play_level > 5'h0f)
        else $error("level not saturated");
    // One symbol per clock, so a run is sixteen active cycles
    sequence seq_half_pattern;
        play_active [*8];
    endsequence

    chk_pattern_len: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(play_active) |-> seq_half_pattern ##1 seq_half_pattern ##1 !play_active)
        else $error("pattern length wrong");
endmodule : cdc_pattern_store

/* design/cdc_regs.sv */
`timescale 1ns/1ns
module cdc_regs (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    // Management register access
    input  wire logic [11:0] reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [15:0] reg_wdata,
    output logic      [15:0] reg_rdata,
    // Measurement engine
    output logic             len_start,
    output logic             ref_start,
    output logic             pair_rx,
    output logic             eng_enable,
    output logic             raw_mode,
    output logic       [3:0] input_sel,
    output logic             sm_config,
    output logic             sm_tx_config,
    input  wire logic        len_done_evt,
    input  wire logic        ref_done_evt,
    input  wire logic        ref_fail,
    input  wire logic [15:0] peak_result [5],
    input  wire logic [15:0] length_result,
    // Pattern output
    output logic       [4:0] pulse_level,
    output logic             pulse_active
);
    logic [2:0]  sel_q, sel_d;
    logic        pair_q, pair_d;
    logic        len_go_q, len_go_d, ref_go_q, ref_go_d;
    logic        len_done_q, len_done_d, ref_done_q, ref_done_d;
    logic        ref_fail_q, ref_fail_d;
    logic [3:0]  inp_q, inp_d;
    logic        eng_q, eng_d, raw_q, raw_d;
    logic        smc_q, smc_d, smt_q, smt_d;
    logic [13:0] smr_q, smr_d;
    logic [4:0]  pamp_q, pamp_d;
    logic [15:0] rdata_q, rdata_d;
    logic [15:0] result_mux;
    logic        armed, pat_we;
    logic [3:0]  unused_ptr;

    function automatic logic wr_hit(input logic [11:0] a, input logic [11:0] o, input logic w);
        wr_hit = w && (a == o);
    endfunction : wr_hit

    assign armed  = smc_q && smt_q;
    assign pat_we = wr_hit(reg_addr, cdc_pkg::ADDR_PATTERN, reg_wr) && armed;

    always_comb begin
        if (sel_q <= cdc_pkg::SEL_LAST_PEAK) begin
            result_mux = peak_result[sel_q];
        end else if (sel_q == cdc_pkg::SEL_LENGTH) begin
            result_mux = length_result;
        end else begin
            result_mux = 16'h0000;
        end
    end

    always_comb begin
        sel_d      = sel_q;
        pair_d     = pair_q;
        inp_d      = inp_q;
        eng_d      = eng_q;
        raw_d      = raw_q;
        smc_d      = smc_q;
        smt_d      = smt_q;
        smr_d      = smr_q;
        pamp_d     = pamp_q;
        len_go_d   = 1'b0; // Self clearing
        ref_go_d   = 1'b0;
        len_done_d = len_done_q;
        ref_done_d = ref_done_q;
        ref_fail_d = ref_fail;
        if (wr_hit(reg_addr, cdc_pkg::ADDR_CONTROL, reg_wr)) begin
            len_go_d = reg_wdata[cdc_pkg::CTL_LEN_START];
            ref_go_d = reg_wdata[cdc_pkg::CTL_REF_START];
            sel_d    = reg_wdata[cdc_pkg::CTL_SEL_LO +: 3];
            pair_d   = reg_wdata[cdc_pkg::CTL_PAIR];
        end
        if (wr_hit(reg_addr, cdc_pkg::ADDR_STATUS, reg_wr)) begin
            inp_d = reg_wdata[cdc_pkg::STS_INPUT_LO +: 4];
            eng_d = reg_wdata[cdc_pkg::STS_ENG_EN];
            raw_d = reg_wdata[cdc_pkg::STS_RAW_MODE];
        end
        if (wr_hit(reg_addr, cdc_pkg::ADDR_SM_EN, reg_wr)) begin
            smc_d = reg_wdata[cdc_pkg::SM_CONFIG];
            smt_d = reg_wdata[cdc_pkg::SM_TX_CONFIG];
            smr_d = reg_wdata[13:0];
        end
        if (pat_we) begin
            pamp_d = reg_wdata[4:0];
        end
        // Launch clears old done; completion in same cycle wins
        if (len_go_d) len_done_d = 1'b0;
        if (ref_go_d) ref_done_d = 1'b0;
        if (len_done_evt) len_done_d = 1'b1;
        if (ref_done_evt) begin
            ref_done_d = 1'b1;
            smc_d      = 1'b0;
            smt_d      = 1'b0;
        end
        rdata_d = rdata_q;
        if (reg_rd) begin
            unique case (reg_addr)
                cdc_pkg::ADDR_CONTROL: rdata_d = {5'h00, sel_q, 7'h00, pair_q};
                cdc_pkg::ADDR_STATUS:  rdata_d = {len_done_q, ref_fail_q, ref_done_q,
                                                  cdc_pkg::STS_RSVD_RESET, inp_q, eng_q,
                                                  raw_q, 4'h0};
                cdc_pkg::ADDR_RESULT:  rdata_d = result_mux;
                cdc_pkg::ADDR_SM_EN:   rdata_d = {smc_q, smt_q, smr_q};
                cdc_pkg::ADDR_PATTERN: rdata_d = {11'h000, pamp_q};
                default:               rdata_d = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sel_q      <= 3'h0;
            pair_q     <= 1'b0;
            len_go_q   <= 1'b0;
            ref_go_q   <= 1'b0;
            len_done_q <= 1'b0;
            ref_done_q <= 1'b0;
            ref_fail_q <= cdc_pkg::REF_FAIL_RESET;
            inp_q      <= cdc_pkg::INPUT_RESET;
            eng_q      <= 1'b0;
            raw_q      <= cdc_pkg::RAW_MODE_RESET;
            smc_q      <= 1'b0;
            smt_q      <= 1'b0;
            smr_q      <= 14'h0000;
            pamp_q     <= 5'h00;
            rdata_q    <= 16'h0000;
        end else begin
            sel_q      <= sel_d;
            pair_q     <= pair_d;
            len_go_q   <= len_go_d;
            ref_go_q   <= ref_go_d;
            len_done_q <= len_done_d;
            ref_done_q <= ref_done_d;
            ref_fail_q <= ref_fail_d;
            inp_q      <= inp_d;
            eng_q      <= eng_d;
            raw_q      <= raw_d;
            smc_q      <= smc_d;
            smt_q      <= smt_d;
            smr_q      <= smr_d;
            pamp_q     <= pamp_d;
            rdata_q    <= rdata_d;
        end
    end

    // Reflectometry launch while armed plays the stored pattern
    cdc_pattern_store u_store (
        .sys_clk     (sys_clk),
        .rst_n       (rst_n),
        .armed       (armed),
        .load_we     (pat_we),
        .load_amp    (reg_wdata[4:0]),
        .play_start  (ref_go_q),
        .play_level  (pulse_level),
        .play_active (pulse_active),
        .load_ptr    (unused_ptr)
    );

    assign reg_rdata    = rdata_q;
    assign len_start    = len_go_q;
    assign ref_start    = ref_go_q;
    assign pair_rx      = pair_q;
    assign eng_enable   = eng_q;
    assign raw_mode     = raw_q;
    assign input_sel    = inp_q;
    assign sm_config    = smc_q;
    assign sm_tx_config = smt_q;

    chk_len_pulse: assert property (@(posedge sys_clk) disable iff (!rst_n)
        wr_hit(reg_addr, cdc_pkg::ADDR_CONTROL, reg_wr) |=>
            len_start == $past(reg_wdata[13]) ##1 !len_start || $past(reg_wr))
        else $error("length start not one pulse");
    chk_ref_pulse: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (reg_wr && reg_addr == cdc_pkg::ADDR_CONTROL && !reg_wdata[12]) |=> !ref_start)
        else $error("zero write launched reflectometry");
    chk_len_done: assert property (@(posedge sys_clk) disable iff (!rst_n)
        len_done_evt |=> len_done_q)
        else $error("done flag not set");
    chk_sm_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ref_done_evt |=> !sm_config && !sm_tx_config && ref_done_q)
        else $error("enables not cleared at completion");
    chk_result_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (reg_rd && reg_addr == cdc_pkg::ADDR_RESULT && (sel_q == 3'h5 || sel_q == 3'h7))
            |=> reg_rdata == 16'h0000)
        else $error("unassigned select not zero");
    chk_pat_gate: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (reg_wr && reg_addr == cdc_pkg::ADDR_PATTERN && !armed) |=> $stable(pamp_q))
        else $error("pattern write taken while disarmed");
    chk_pair_sel: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (reg_wr && reg_addr == cdc_pkg::ADDR_CONTROL) |=> pair_rx == $past(reg_wdata[0]))
        else $error("pair select not stored");
endmodule : cdc_regs

/* testbench/cable_diag_control_tb.sv */
`timescale 1ns/1ns
module cable_diag_control_tb;
    logic        sys_clk      = 1'b0;
    logic        rst_n        = 1'b0;
    logic [11:0] reg_addr     = 12'h000;
    logic        reg_wr       = 1'b0;
    logic        reg_rd       = 1'b0;
    logic [15:0] reg_wdata    = 16'h0000;
    logic        len_done_evt = 1'b0;
    logic        ref_done_evt = 1'b0;
    logic        ref_fail     = 1'b1;
    logic [15:0] length_result = 16'h0000;
    logic [15:0] peak [5];
    logic [15:0] reg_rdata;
    logic        len_start;
    logic        ref_start;
    logic        pair_rx;
    logic        eng_enable;
    logic        raw_mode;
    logic [3:0]  input_sel;
    logic        sm_config;
    logic        sm_tx_config;
    logic [4:0]  pulse_level;
    logic        pulse_active;
    logic [15:0] rd;
    logic [4:0]  amp [16];
    logic [4:0]  v;
    integer      seed   = 32'hd9f1;
    int          errors = 0;
    int          checks = 0;
    int          n;

    always #5 sys_clk = ~sys_clk;

    cdc_regs uut (
        .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .len_start(len_start), .ref_start(ref_start), .pair_rx(pair_rx),
        .eng_enable(eng_enable), .raw_mode(raw_mode), .input_sel(input_sel),
        .sm_config(sm_config), .sm_tx_config(sm_tx_config),
        .len_done_evt(len_done_evt), .ref_done_evt(ref_done_evt), .ref_fail(ref_fail),
        .peak_result(peak), .length_result(length_result),
        .pulse_level(pulse_level), .pulse_active(pulse_active)
    );

    task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task wr(input logic [11:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task rdr(input logic [11:0] a, output logic [15:0] d);
        @(posedge sys_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rdr

    task pulse_evt(input bit which);
        @(posedge sys_clk);
        if (which) ref_done_evt <= 1'b1;
        else len_done_evt <= 1'b1;
        @(posedge sys_clk);
        ref_done_evt <= 1'b0;
        len_done_evt <= 1'b0;
    endtask : pulse_evt

    // Codes without a result read zero
    function automatic logic [15:0] exp_result(input logic [2:0] s);
        if (s <= 3'h4) return peak[s];
        if (s == 3'h6) return length_result;
        return 16'h0000;
    endfunction : exp_result

    function automatic logic [4:0] sat(input logic [4:0] a);
        return (a >= 5'h08) ? cdc_pkg::AMP_FULL : a;
    endfunction : sat

    task finish_test;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : finish_test

    initial begin
        repeat (5000) @(posedge sys_clk);
        errors++;
        finish_test();
    end

    initial begin
        foreach (peak[i]) peak[i] = 16'h0000;
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        rdr(cdc_pkg::ADDR_STATUS, rd);
        check("status reset", rd, 16'h51d0);
        rdr(cdc_pkg::ADDR_SM_EN, rd);
        check("sm reset", rd, 16'h0000);
        $display("test reset done");
        wr(cdc_pkg::ADDR_CONTROL, 16'h2000);
        #1 check("len_start", {15'h0, len_start}, 16'h1);
        check("ref_start idle", {15'h0, ref_start}, 16'h0);
        @(posedge sys_clk);
        #1 check("len_start one cycle", {15'h0, len_start}, 16'h0);
        wr(cdc_pkg::ADDR_CONTROL, 16'h1000);
        #1 check("ref_start", {15'h0, ref_start}, 16'h1);
        check("len_start idle", {15'h0, len_start}, 16'h0);
        wr(cdc_pkg::ADDR_CONTROL, 16'h0001);
        #1 check("no launch", {14'h0, len_start, ref_start}, 16'h0);
        check("pair_rx", {15'h0, pair_rx}, 16'h1);
        rdr(cdc_pkg::ADDR_CONTROL, rd);
        check("control self clear", rd, 16'h0001);
        $display("test launch done");
        for (int s = 0; s < 8; s++) begin
            @(posedge sys_clk);
            foreach (peak[i]) peak[i] <= 16'($random(seed));
            length_result <= 16'($random(seed));
            wr(cdc_pkg::ADDR_CONTROL, {5'h00, 3'(s), 8'h00});
            rdr(cdc_pkg::ADDR_RESULT, rd);
            check("result", rd, exp_result(3'(s)));
        end
        $display("test result select done");
        @(posedge sys_clk);
        ref_fail <= 1'b0;
        pulse_evt(1'b0);
        rdr(cdc_pkg::ADDR_STATUS, rd);
        check("status len done", rd, 16'h91d0);
        wr(cdc_pkg::ADDR_STATUS, 16'h0160);
        #1 check("mode adaptive", {10'h0, input_sel, eng_enable, raw_mode}, 16'h0016);
        wr(cdc_pkg::ADDR_STATUS, 16'h00d0);
        #1 check("mode raw", {10'h0, input_sel, eng_enable, raw_mode}, 16'h000d);
        rdr(cdc_pkg::ADDR_STATUS, rd);
        check("status mode", rd, 16'h90d0);
        $display("test status done");
        wr(cdc_pkg::ADDR_SM_EN, 16'hc000);
        #1 check("sm set", {14'h0, sm_config, sm_tx_config}, 16'h3);
        pulse_evt(1'b1);
        rdr(cdc_pkg::ADDR_SM_EN, rd);
        check("sm cleared", rd, 16'h0000);
        rdr(cdc_pkg::ADDR_STATUS, rd);
        check("status ref done", rd, 16'hb0d0);
        $display("test sm clear done");
        // Seventeenth write wraps onto symbol zero
        wr(cdc_pkg::ADDR_SM_EN, 16'hc000);
        for (int i = 0; i < 17; i++) begin
            v = 5'($random(seed) & 15);
            if (i == 0) v = 5'h03;
            if (i == 1) v = 5'h08;
            if (i == 2) v = 5'h0f;
            if (i == 16) v = 5'h0c;
            amp[i % 16] = v;
            wr(cdc_pkg::ADDR_PATTERN, {11'h000, v});
        end
        wr(cdc_pkg::ADDR_CONTROL, 16'h1000);
        n = 0;
        while (pulse_active !== 1'b1 && n < 20) begin
            @(posedge sys_clk);
            #1 n++;
        end
        if (n == 20) begin
            errors++;
        end
        for (int i = 0; i < 16; i++) begin
            check("pulse level", {11'h0, pulse_level}, {11'h0, sat(amp[i])});
            @(posedge sys_clk);
            #1;
        end
        check("playback end", {15'h0, pulse_active}, 16'h0);
        // Only one enable set: pattern writes and playback must be refused
        wr(cdc_pkg::ADDR_SM_EN, 16'h4000);
        wr(cdc_pkg::ADDR_PATTERN, 16'h001f);
        rdr(cdc_pkg::ADDR_PATTERN, rd);
        check("pattern gated", rd, {11'h000, amp[0]});
        wr(cdc_pkg::ADDR_CONTROL, 16'h1000);
        @(posedge sys_clk);
        #1 check("no playback disarmed", {15'h0, pulse_active}, 16'h0);
        $display("test pattern done");
        finish_test();
    end
endmodule : cable_diag_control_tb
